// file: common/ocpm_pkg.sv
// Summary of operation
// - voltage checks sampled, over-current check continuous
// - monitor mode keeps voltage checks continuous
// - all select inputs low means normal
// - sample window 2ms every 125ms
// - over-threshold starts delay, still normal
// - delay expiry with over-threshold: charge drive high
// - entering protection leaves discharge drive alone
// - detection delay is a parameter
// - charge control writes held until release
// - discharge control still works in protection
// - release below release threshold, charge drive low
// - release leaves discharge drive alone
// - thresholds software selectable, kept stored
// - control bit one drives output low
// - mode status equals protection mode
package ocpm_pkg;
  // clock rate and times
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SAMPLE_ON_US    = 2_000;
  localparam int unsigned SAMPLE_PERIOD_US = 125_000;
  localparam int unsigned DETECT_DELAY_MS = 1_000;
  // cycle counts, on time and period both exact
  localparam int unsigned SAMPLE_ON_CYC     = SAMPLE_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DETECT_DELAY_CYC  = DETECT_DELAY_MS * (CLK_HZ / 1_000);
  // register indices
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MK = 4'h4;
  // field positions
  localparam int CTRL_CHG_BIT = 0;
  localparam int CTRL_DIS_BIT = 1;
  // reset values
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam logic [5:0] CONFIG_RESET = 6'h00;
  // interrupt events
  localparam int IRQ_ENTER = 0;
  localparam int IRQ_LEAVE = 1;
  // protection states
  typedef enum logic [1:0] {ST_NORMAL, ST_DELAY, ST_PROTECT} ocpm_state_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ocpm_req_t;
endpackage

// file: dv/ocpm_fet_model.sv
`timescale 1ns/1ps
// external p-channel charge and discharge fets
module ocpm_fet_model (
  // gate drives from the monitor
  input  wire logic gate_chg,
  input  wire logic gate_dis,
  // conduction state seen by the pack
  output logic      chg_on,
  output logic      dis_on
);
  // low gate turns a p-channel fet on, unknown stays unknown
  assign chg_on = (gate_chg == 1'b0);
  assign dis_on = (gate_dis == 1'b0);
endmodule // ocpm_fet_model

// file: dv/overcharge_protection_monitor_test.sv
`timescale 1ns/1ps
module overcharge_protection_monitor_test;
  import ocpm_pkg::*;
  logic       mclk, reset_n, wr, rd, rd_d, over, above;
  logic       volt_en, curr_en, chg_drv, dis_drv, st, irq, chg_on, dis_on;
  logic [2:0] sel;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, n;
  logic [5:0] cfg, rv;
  logic [7:0] exp_q[$];   // expected read data, oldest first
  int         errors, tests_run;
  // short counts so the run stays brief
  ocpm_monitor #(.DELAY_CYC(20), .PERIOD_CYC(20), .ON_CYC(4)) DUT (
    .MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .ANALOG_SEL_0(sel[0]), .ANALOG_SEL_1(sel[1]),
    .ANALOG_SEL_2(sel[2]), .CELL_OVER_THRESH(over), .CELL_ABOVE_RELEASE(above),
    .VOLT_CMP_EN(volt_en), .CURR_CMP_EN(curr_en), .THRESH_CFG(cfg),
    .CHARGE_FET_DRIVE(chg_drv), .DISCHARGE_FET_DRIVE(dis_drv),
    .OVERCHARGE_MODE_STATUS(st), .IRQ(irq));
  ocpm_fet_model fets (.gate_chg(chg_drv), .gate_dis(dis_drv),
    .chg_on(chg_on), .dis_on(dis_on));
  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard, tests need well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // one-cycle read strobe, expectation queued
  task automatic rd_reg(logic [3:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  // pins as {status, irq, charge fet on, discharge fet on}
  task automatic pins(int w, logic [3:0] e);
    repeat (w) @(posedge mclk);
    #1 check("pins", {4'h0, st, irq, chg_on, dis_on}, {4'h0, e});
  endtask
  // count cycles with voltage comparators enabled
  task automatic count_en(int c, logic [7:0] e);
    n = 8'h00;
    repeat (8) @(posedge mclk);
    repeat (c)
    begin
      @(posedge mclk);
      n = n + {7'h00, volt_en};
    end
    check("volt_en", n, e);
    check("curr_en", {7'h00, curr_en}, 8'h01);
  endtask
  // read data compared the cycle after the strobe
  always @(posedge mclk)
  begin
    rd_d <= rd;
    if (rd_d)
      check("rdata", rdata, exp_q.pop_front());
  end
  initial
  begin
    {reset_n, wr, rd, rd_d, over, above, sel, addr, wdata} = '0;
    errors = 0;
    tests_run = 0;
    void'($urandom(19));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    pins(2, 4'h0);
    rd_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_CTRL, 8'h03);
    pins(4, 4'h3);
    rv = 6'($urandom);
    wr_reg(ADDR_CONFIG, {2'h0, rv});
    rd_reg(ADDR_CONFIG, {2'h0, rv});
    #1 check("cfg", {2'h0, cfg}, {2'h0, rv});
    $display("test registers done");
    // each select pin alone, then a random mix, means monitor mode
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      sel <= (i < 3) ? 3'h1 << i : 3'($urandom_range(7, 1));
      count_en(20, 8'd20);
    end
    @(posedge mclk);
    sel <= 3'h0;
    count_en(40, 8'd8);
    $display("test sampling done");
    // short excursion, then a full one, in monitor mode
    sel   <= 3'h1;
    over  <= 1'b1;
    above <= 1'b1;
    repeat (5) @(posedge mclk);
    over  <= 1'b0;
    above <= 1'b0;
    pins(40, 4'h3);
    @(posedge mclk);
    over  <= 1'b1;
    above <= 1'b1;
    pins(10, 4'h3);
    pins(30, 4'h9);
    rd_reg(ADDR_STATUS, 8'h04);
    rd_reg(ADDR_IRQ_ST, 8'h01);
    wr_reg(ADDR_IRQ_MK, 8'h03);
    pins(3, 4'hd);
    wr_reg(ADDR_IRQ_ST, 8'h01);
    pins(3, 4'h9);
    wr_reg(ADDR_CTRL, 8'h01);
    pins(4, 4'h8);
    @(posedge mclk);
    over  <= 1'b0;
    above <= 1'b0;
    pins(10, 4'h6);
    $display("test protection done");
    rd_reg(ADDR_IRQ_ST, 8'h02);
    wr_reg(ADDR_IRQ_ST, 8'h03);
    pins(3, 4'h2);
    rd_reg(4'h5, 8'h00);
    rd_reg(ADDR_IRQ_MK, 8'h03);
    repeat (3) @(posedge mclk);
    $display("test interrupts done");
    // mid-run reset turns both fets off and clears the bits
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    pins(2, 4'h0);
    rd_reg(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge mclk);
    $display("test reset done");
    report_and_stop();
  end
endmodule // overcharge_protection_monitor_test

// file: rtl/ocpm_monitor.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ocpm_monitor
  import ocpm_pkg::*;
#(
  parameter int unsigned DELAY_CYC  = DETECT_DELAY_CYC,
  parameter int unsigned PERIOD_CYC = SAMPLE_PERIOD_CYC,
  parameter int unsigned ON_CYC     = SAMPLE_ON_CYC
)(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // analog select pins
  input  wire logic       ANALOG_SEL_0,
  input  wire logic       ANALOG_SEL_1,
  input  wire logic       ANALOG_SEL_2,
  // comparator results, asynchronous
  input  wire logic       CELL_OVER_THRESH,
  input  wire logic       CELL_ABOVE_RELEASE,
  // comparator gating
  output logic            VOLT_CMP_EN,
  output logic            CURR_CMP_EN,
  output logic [5:0]      THRESH_CFG,
  // fet drives, high turns fet off
  output logic            CHARGE_FET_DRIVE,
  output logic            DISCHARGE_FET_DRIVE,
  output logic            OVERCHARGE_MODE_STATUS,
  output logic            IRQ
);
  ocpm_req_t   req;                    // bundled register request
  logic [2:0]  sel_s1_reg, sel_s2_reg; // select synchroniser
  logic [1:0]  cmp_s1_reg, cmp_s2_reg; // comparator synchroniser
  logic        monitor_mode;           // any select high
  logic [31:0] period_cnt_reg;         // sample timer
  logic        sample_on;              // comparators live
  logic [31:0] delay_cnt_reg;          // detection delay
  ocpm_state_t state_reg, state_next;  // protection state
  logic [1:0]  ctrl_reg;               // fet control bits
  logic [5:0]  config_reg;             // threshold selects
  logic [1:0]  irq_st_reg, irq_mk_reg; // interrupt status, mask
  logic        over, above_rel;        // synchronised comparator levels

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // write strobe aimed at one register index
  function automatic logic wr_hit(ocpm_req_t r, logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // two-flop synchronisers for pins
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      sel_s1_reg <= 3'h0;
      sel_s2_reg <= 3'h0;
      cmp_s1_reg <= 2'h0;
      cmp_s2_reg <= 2'h0;
    end
    else
    begin
      sel_s1_reg <= {ANALOG_SEL_2, ANALOG_SEL_1, ANALOG_SEL_0};
      sel_s2_reg <= sel_s1_reg;
      cmp_s1_reg <= {CELL_ABOVE_RELEASE, CELL_OVER_THRESH};
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  assign monitor_mode = |sel_s2_reg;
  assign over         = cmp_s2_reg[0];
  assign above_rel    = cmp_s2_reg[1];
  assign sample_on    = monitor_mode || (period_cnt_reg < ON_CYC);

  // sample period timer
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || period_cnt_reg == PERIOD_CYC - 1)
      period_cnt_reg <= 32'h0;
    else
      period_cnt_reg <= period_cnt_reg + 32'h1;
  end

  // comparator enables
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      VOLT_CMP_EN <= 1'b0;
      CURR_CMP_EN <= 1'b0;
    end
    else
    begin
      VOLT_CMP_EN <= sample_on;
      CURR_CMP_EN <= 1'b1;
    end
  end

  // protection state next value
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NORMAL:
        if (sample_on && over)
          state_next = ST_DELAY;
      ST_DELAY:
        if (sample_on && !over)
          state_next = ST_NORMAL;
        else if (delay_cnt_reg >= DELAY_CYC - 1 && over)
          state_next = ST_PROTECT;
      ST_PROTECT:
        if (sample_on && !above_rel)
          state_next = ST_NORMAL;
      default:
        state_next = ST_NORMAL;
    endcase
  end

  // state and delay counter
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      state_reg     <= ST_NORMAL;
      delay_cnt_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_DELAY)
        delay_cnt_reg <= delay_cnt_reg + 32'h1;
      else
        delay_cnt_reg <= 32'h0;
    end
  end

  // control and config registers
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      ctrl_reg   <= CTRL_RESET;
      config_reg <= CONFIG_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == ADDR_CTRL)
        ctrl_reg <= req.wdata[1:0];
      if (req.addr == ADDR_CONFIG)
        config_reg <= req.wdata[5:0];
    end
  end

  // fet drives, low means fet on
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      CHARGE_FET_DRIVE       <= 1'b1;
      DISCHARGE_FET_DRIVE    <= 1'b1;
      OVERCHARGE_MODE_STATUS <= 1'b0;
      THRESH_CFG             <= CONFIG_RESET;
    end
    else
    begin
      if (state_next == ST_PROTECT)
        CHARGE_FET_DRIVE <= 1'b1;
      else if (state_reg == ST_PROTECT)
        CHARGE_FET_DRIVE <= 1'b0;
      else
        CHARGE_FET_DRIVE <= !ctrl_reg[CTRL_CHG_BIT];
      DISCHARGE_FET_DRIVE    <= !ctrl_reg[CTRL_DIS_BIT];
      OVERCHARGE_MODE_STATUS <= (state_next == ST_PROTECT);
      THRESH_CFG             <= config_reg;
    end
  end

  // interrupt status, set beats clear
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      irq_st_reg <= 2'h0;
      irq_mk_reg <= 2'h0;
      IRQ        <= 1'b0;
    end
    else
    begin
      irq_st_reg[IRQ_ENTER] <= (state_next == ST_PROTECT && state_reg != ST_PROTECT)
        || (irq_st_reg[IRQ_ENTER] && !(wr_hit(req, ADDR_IRQ_ST) && req.wdata[0]));
      irq_st_reg[IRQ_LEAVE] <= (state_next != ST_PROTECT && state_reg == ST_PROTECT)
        || (irq_st_reg[IRQ_LEAVE] && !(wr_hit(req, ADDR_IRQ_ST) && req.wdata[1]));
      if (wr_hit(req, ADDR_IRQ_MK))
        irq_mk_reg <= req.wdata[1:0];
      IRQ <= |(irq_st_reg & irq_mk_reg);
    end
  end

  // read data one cycle later
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      RDATA <= 8'h00;
    else if (req.rd)
      unique case (req.addr)
        ADDR_CTRL:   RDATA <= {6'h00, ctrl_reg};
        ADDR_CONFIG: RDATA <= {2'h0, config_reg};
        ADDR_STATUS: RDATA <= {5'h00, (state_reg == ST_PROTECT), 2'h0};
        ADDR_IRQ_ST: RDATA <= {6'h00, irq_st_reg};
        ADDR_IRQ_MK: RDATA <= {6'h00, irq_mk_reg};
        default:     RDATA <= 8'h00;
      endcase
    else
      RDATA <= 8'h00;
  end

  // checks
  // entry, release and cancel steps of the protection state
  sequence enter_s;
    state_reg != ST_PROTECT && state_next == ST_PROTECT;
  endsequence
  sequence leave_s;
    state_reg == ST_PROTECT && state_next != ST_PROTECT;
  endsequence
  sequence cancel_s;
    state_reg == ST_DELAY && state_next == ST_NORMAL;
  endsequence
  // delay still short of its end count
  sequence delay_run_s;
    state_reg == ST_DELAY && delay_cnt_reg < DELAY_CYC - 1;
  endsequence

  // status flag tracks the protection state
  status_mode_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    OVERCHARGE_MODE_STATUS == (state_reg == ST_PROTECT))
    else $error("status differs from mode");
  // charge fet off for the whole protection stay
  enter_drive_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_PROTECT) |-> CHARGE_FET_DRIVE)
    else $error("charge drive low in protection");
  // control writes do not reach the charge pin
  held_write_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_PROTECT && state_next == ST_PROTECT) |=> CHARGE_FET_DRIVE)
    else $error("charge write leaked");
  // release turns the charge fet back on
  release_low_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_PROTECT && state_next == ST_NORMAL) |=> !CHARGE_FET_DRIVE)
    else $error("release did not turn fet on");
  // discharge pin always follows its control bit
  dis_follow_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    1'b1 |=> DISCHARGE_FET_DRIVE == !$past(ctrl_reg[CTRL_DIS_BIT]))
    else $error("discharge drive wrong");
  // current comparator never gated
  curr_always_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    $past(RESET_N) |-> CURR_CMP_EN)
    else $error("current check off");
  // monitor mode keeps voltage comparators live
  mon_cont_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    monitor_mode |=> VOLT_CMP_EN)
    else $error("monitor mode not continuous");
  // early drop ends the delay
  cancel_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_DELAY && sample_on && !over) |=> state_reg == ST_NORMAL)
    else $error("delay not cancelled");
  // comparators off past the window end
  normal_off_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (!monitor_mode && period_cnt_reg >= ON_CYC) |=> !VOLT_CMP_EN)
    else $error("sample window too long");
  // comparators on at each period start
  window_start_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (!monitor_mode && period_cnt_reg == 32'h0) |=> VOLT_CMP_EN)
    else $error("sample window missing");
  // no detection outside the sample window
  gate_idle_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_NORMAL && !sample_on) |=> state_reg == ST_NORMAL)
    else $error("state left normal outside window");
  // delay counting is still normal operation
  delay_normal_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_DELAY) |->
      (!OVERCHARGE_MODE_STATUS && CHARGE_FET_DRIVE == !$past(ctrl_reg[CTRL_CHG_BIT])))
    else $error("delay left normal operation");
  // protection never before the full delay
  early_expire_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    delay_run_s |=> state_reg != ST_PROTECT)
    else $error("protection before delay end");
  // entry raises status and turns charge fet off
  enter_mark_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    enter_s |=> OVERCHARGE_MODE_STATUS && CHARGE_FET_DRIVE)
    else $error("entry not shown");
  // entry leaves the discharge pin alone
  enter_keep_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    enter_s ##0 $stable(ctrl_reg) |=> $stable(DISCHARGE_FET_DRIVE))
    else $error("entry moved discharge drive");
  // no release while a cell stays above release level
  hold_protect_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ST_PROTECT && above_rel) |=> state_reg == ST_PROTECT)
    else $error("released above release level");
  // release leaves the discharge pin alone
  leave_keep_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    leave_s ##0 $stable(ctrl_reg) |=> $stable(DISCHARGE_FET_DRIVE))
    else $error("release moved discharge drive");
  // cancel never switches the charge fet
  cancel_keep_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    cancel_s ##0 $stable(ctrl_reg) |=> $stable(CHARGE_FET_DRIVE))
    else $error("cancel switched charge drive");
endmodule // ocpm_monitor
